/* logic/fps_defs.svh */
// constants for the fine phase shift control block
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH

// ****************************************
// shift amount
// ****************************************
`define FPS_SHIFT_W 9
`define FPS_SHIFT_MAX 9'sh0FF
`define FPS_SHIFT_MIN 9'sh101
`define FPS_SHIFT_RST 9'sh000
`define FPS_SHIFT_ONE 9'sh001
`define FPS_FRAC_DIV 26'sh0000100
`define FPS_FRAC_BITS 8

// ****************************************
// phase of each output, in 1/256 of its period
// ****************************************
`define FPS_PHASE_W 11
`define FPS_PHASE_RST 11'sh000
`define FPS_CO_ZERO 11'sh000
`define FPS_CO_QUARTER 11'sh040
`define FPS_CO_HALF 11'sh080
`define FPS_CO_THREE_Q 11'sh0C0
`define FPS_NUM_OUT 9

// ****************************************
// output index
// ****************************************
`define FPS_IX_ZERO 0
`define FPS_IX_QUARTER 1
`define FPS_IX_HALF 2
`define FPS_IX_THREE_Q 3
`define FPS_IX_DOUBLED 4
`define FPS_IX_DOUBLED_INV 5
`define FPS_IX_DIVIDED 6
`define FPS_IX_SYNTH 7
`define FPS_IX_SYNTH_INV 8

// ****************************************
// timing
// ****************************************
`define FPS_PERIOD_W 16
`define FPS_TIME_W 17
`define FPS_TIME_RST 17'sh00000
`define FPS_TAP_PS_DEF 16'h001E
`define FPS_RES_RST 16'h0000

`endif

/* logic/fps_pkg.sv */
// types shared by the fine phase shift control block
`default_nettype none
package fps_pkg;
   typedef enum logic [1:0] {FPS_NONE, FPS_FIXED, FPS_VARIABLE} fps_mode_t;
   typedef enum logic [1:0] {ST_OFF, ST_FIXED, ST_VARIABLE, ST_BADCFG}
      fps_state_t;
   typedef logic signed [8:0] fps_shift_t;
   typedef logic signed [10:0] fps_phase_t;
endpackage : fps_pkg
`default_nettype wire

/* logic/fps_sync.sv */
// three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/10ps
`default_nettype none
module fps_sync #(
   parameter int W = 3
) (
   input wire logic clk,           // system clock
   input wire logic rst,           // synchronous reset
   input wire logic [W-1:0] d,     // asynchronous pins
   output logic [W-1:0] q,         // filtered level
   output logic [W-1:0] rise       // one-cycle pulse on rising level
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   wire [W-1:0] agree = ~(s2 ^ s3);
   wire [W-1:0] next_q = (s2 & agree) | (q & ~agree);

   // s1 feeds only s2; the filter looks at s2 and s3
   always_ff @(posedge clk) begin
      if (rst) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         q <= '0;
         rise <= '0;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         q <= next_q;
         rise <= next_q & ~q;
      end
   end
endmodule : fps_sync
`default_nettype wire

/* logic/fps_top.sv */
// fine phase shift control of the clock manager delay-locked loop
// ****************************************
// How it works
// - the shift unit works only while low_freq_mode is high.
// - nine outputs keep fixed coarse phases of 0, 90, 180, 270 degrees.
// - a shift amount outside -255..+255 is rejected as bad config.
// - fine shift time is reference period times shift over 256.
// - resolution is the larger of period/256 and the tap delay.
// - all nine outputs carry the same fine shift at once.
// - outputs with a coarse offset get the fine shift added to it.
// - the mode is none, fixed or variable.
// - with the unit disabled the shift is held at zero.
// - a zero shift leaves feedback and reference in phase.
// - a positive shift marks the feedback clock as later.
// - a negative shift marks the feedback clock as earlier.
// - fixed and variable modes share one shift time calculation.
// ****************************************
`timescale 1ns/10ps
`default_nettype none
`include "fps_defs.svh"
module fps_top #(
   parameter logic [15:0] TAP_PS = `FPS_TAP_PS_DEF
) (
   input wire logic clk,                           // 100 MHz clock
   input wire logic rst,                           // sync reset, high
   input wire logic low_freq_mode,                 // loop in low-freq mode
   input wire fps_pkg::fps_mode_t shift_mode_attribute, // none/fixed/var
   input wire logic signed [8:0] shift_amount,     // configured shift
   input wire logic [15:0] ref_period_ps,          // reference period
   input wire logic phase_step_enable,             // step request pin
   input wire logic phase_step_clock,              // step clock pin
   input wire logic phase_step_direction,          // 1 up, 0 down
   output logic shift_active,                      // unit in use
   output logic config_error,                      // bad mode or value
   output logic signed [8:0] fine_shift_units,     // live shift
   output logic signed [16:0] fine_shift_time_ps,  // shift in ps
   output logic [15:0] resolution_ps,              // step size in ps
   output logic feedback_later,                    // feedback lags
   output logic feedback_earlier,                  // feedback leads
   output logic step_done,                         // step applied
   output logic stray_step,                        // step while not var
   output logic [8:0][10:0] out_phase              // per-output phase
);
   import fps_pkg::*;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic in_range(input fps_shift_t v);
      in_range = (v >= `FPS_SHIFT_MIN) && (v <= `FPS_SHIFT_MAX);
   endfunction : in_range

   function automatic fps_phase_t add_coarse(input fps_phase_t c,
                                             input fps_shift_t f);
      add_coarse = c + {{2{f[8]}}, f};
   endfunction : add_coarse

   function automatic logic signed [16:0] shift_time(
      input logic [15:0] per, input fps_shift_t f);
      logic signed [25:0] prod;
      prod = $signed({1'b0, per}) * f;
      // divide rounds toward zero so +n and -n give mirrored times
      prod = prod / `FPS_FRAC_DIV;
      shift_time = prod[16:0];
   endfunction : shift_time

   // coarse offsets; doubled inverted and synthesized inverted are half period
   localparam fps_phase_t COARSE [`FPS_NUM_OUT] = '{
      `FPS_CO_ZERO, `FPS_CO_QUARTER, `FPS_CO_HALF, `FPS_CO_THREE_Q,
      `FPS_CO_ZERO, `FPS_CO_HALF, `FPS_CO_ZERO, `FPS_CO_ZERO,
      `FPS_CO_HALF};

   // ****************************************
   // step pins
   // ****************************************
   logic [2:0] pin_level;
   logic [2:0] pin_rise;

   fps_sync #(.W(3)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({phase_step_direction, phase_step_clock, phase_step_enable}),
      .q(pin_level),
      .rise(pin_rise)
   );

   wire step_edge = pin_rise[1];
   wire step_en = pin_level[0];
   wire step_up = pin_level[2];

   // ****************************************
   // mode state
   // ****************************************
   fps_state_t state;
   fps_state_t next_state;
   fps_shift_t units;
   fps_shift_t next_units;

   wire cfg_ok = in_range(shift_amount);
   wire at_max = (units == `FPS_SHIFT_MAX);
   wire at_min = (units == `FPS_SHIFT_MIN);

   always_comb begin
      next_state = ST_OFF;
      if (low_freq_mode) begin
         case (shift_mode_attribute)
            FPS_NONE: begin
               next_state = ST_OFF;
            end
            FPS_FIXED: begin
               next_state = cfg_ok ? ST_FIXED : ST_BADCFG;
            end
            FPS_VARIABLE: begin
               next_state = cfg_ok ? ST_VARIABLE : ST_BADCFG;
            end
            default: begin
               next_state = ST_BADCFG;
            end
         endcase
      end
   end

   wire var_stay = (state == ST_VARIABLE) && (next_state == ST_VARIABLE);
   wire step_take = var_stay && step_edge && step_en;
   // an edge outside variable mode means the pins were not tied low
   wire step_stray = step_edge && (next_state != ST_VARIABLE);

   always_comb begin
      next_units = `FPS_SHIFT_RST;
      case (next_state)
         ST_OFF: begin
            next_units = `FPS_SHIFT_RST;
         end
         ST_FIXED: begin
            next_units = shift_amount;
         end
         ST_VARIABLE: begin
            if (!var_stay) begin
               next_units = shift_amount;
            end else if (step_take && step_up && !at_max) begin
               next_units = units + `FPS_SHIFT_ONE;
            end else if (step_take && !step_up && !at_min) begin
               next_units = units - `FPS_SHIFT_ONE;
            end else begin
               next_units = units;
            end
         end
         default: begin
            next_units = `FPS_SHIFT_RST;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ST_OFF;
         units <= `FPS_SHIFT_RST;
      end else begin
         state <= next_state;
         units <= next_units;
      end
   end

   // ****************************************
   // derived outputs
   // ****************************************
   wire [15:0] per_frac = ref_period_ps >> `FPS_FRAC_BITS;
   wire [15:0] next_res = (per_frac > TAP_PS) ? per_frac : TAP_PS;
   wire signed [16:0] next_time = shift_time(ref_period_ps, units);

   always_ff @(posedge clk) begin
      if (rst) begin
         shift_active <= 1'b0;
         config_error <= 1'b0;
         fine_shift_units <= `FPS_SHIFT_RST;
         fine_shift_time_ps <= `FPS_TIME_RST;
         resolution_ps <= `FPS_RES_RST;
         feedback_later <= 1'b0;
         feedback_earlier <= 1'b0;
         step_done <= 1'b0;
         stray_step <= 1'b0;
      end else begin
         shift_active <= (state == ST_FIXED) || (state == ST_VARIABLE);
         config_error <= (state == ST_BADCFG);
         fine_shift_units <= units;
         fine_shift_time_ps <= next_time;
         resolution_ps <= next_res;
         feedback_later <= (units > `FPS_SHIFT_RST);
         feedback_earlier <= (units < `FPS_SHIFT_RST);
         step_done <= step_take;
         stray_step <= step_stray;
      end
   end

   // every output moves by the same fine shift in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < `FPS_NUM_OUT; i++) begin
            out_phase[i] <= `FPS_PHASE_RST;
         end
      end else begin
         for (int i = 0; i < `FPS_NUM_OUT; i++) begin
            out_phase[i] <= add_coarse(COARSE[i], units);
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   slow_mode_off_a: assert property (
      !low_freq_mode |=> (units == `FPS_SHIFT_RST) ##1 !shift_active)
      else $error("shift unit active outside low-frequency mode");

   shift_range_a: assert property (
      in_range(units) && !(state == ST_BADCFG && units != `FPS_SHIFT_RST))
      else $error("shift outside -255..255");

   shift_time_a: assert property (
      !rst |=> fine_shift_time_ps ==
          ($signed({1'b0, $past(ref_period_ps)}) * $past(units)) /
          `FPS_FRAC_DIV)
      else $error("shift time not period times shift over 256");

   resolution_max_a: assert property (
      !rst |=> (resolution_ps >= TAP_PS) &&
          (resolution_ps >= ($past(ref_period_ps) >> `FPS_FRAC_BITS)))
      else $error("resolution below tap or period/256");

   same_shift_a: assert property (
      ##1 (out_phase[`FPS_IX_ZERO] == {{2{$past(units[8])}}, $past(units)})
          && (out_phase[`FPS_IX_DIVIDED] == out_phase[`FPS_IX_SYNTH]))
      else $error("outputs do not share the fine shift");

   coarse_add_a: assert property (
      !rst |=> out_phase[`FPS_IX_HALF] ==
          add_coarse(`FPS_CO_HALF, $past(units)))
      else $error("fine shift not added to coarse offset");

   disabled_zero_a: assert property (
      (state == ST_OFF) |-> (units == `FPS_SHIFT_RST) ##1 !shift_active)
      else $error("disabled unit holds non-zero shift");

   fixed_load_a: assert property (
      (next_state == ST_FIXED) |=> (units == $past(shift_amount)))
      else $error("fixed mode does not follow shift amount");

   fixed_ignore_a: assert property (
      (next_state == ST_FIXED && step_edge) |=>
         !step_done && stray_step && (units == $past(shift_amount)))
      else $error("step applied in fixed mode");

   sign_flags_a: assert property (
      (units == `FPS_SHIFT_RST) |=> !feedback_later && !feedback_earlier)
      else $error("zero shift not reported in phase");

   later_flag_a: assert property (
      (units > `FPS_SHIFT_RST) |=> feedback_later && !feedback_earlier)
      else $error("positive shift not reported later");

   step_up_a: assert property (
      (step_take && step_up && !at_max) |=>
         (units == $past(units) + `FPS_SHIFT_ONE) ##1 $past(step_done))
      else $error("up step did not add one unit");

   step_down_a: assert property (
      (step_take && !step_up && !at_min) |=>
         (units == $past(units) - `FPS_SHIFT_ONE))
      else $error("down step did not subtract one unit");

   earlier_flag_a: assert property (
      (units < `FPS_SHIFT_RST) |=> feedback_earlier && !feedback_later)
      else $error("negative shift not reported earlier");

   step_sat_a: assert property (
      (step_take && ((step_up && at_max) || (!step_up && at_min))) |=>
         (units == $past(units)) && step_done)
      else $error("step past the shift limit was not held");

   stray_off_a: assert property (
      (next_state == ST_OFF && step_edge) |=> stray_step && !step_done)
      else $error("step edge in mode none not flagged");

   bad_cfg_a: assert property (
      (low_freq_mode && (shift_mode_attribute != FPS_NONE) &&
         !in_range(shift_amount)) |=> (units == `FPS_SHIFT_RST) ##1 config_error)
      else $error("out of range shift not flagged");

   quarter_add_a: assert property (
      !rst |=> out_phase[`FPS_IX_QUARTER] ==
          add_coarse(`FPS_CO_QUARTER, $past(units)))
      else $error("fine shift not added to quarter offset");

   inv_half_a: assert property (
      !rst |=>
         (out_phase[`FPS_IX_DOUBLED_INV] == out_phase[`FPS_IX_HALF]) &&
         (out_phase[`FPS_IX_SYNTH_INV] == out_phase[`FPS_IX_HALF]))
      else $error("inverted outputs differ from the half-phase output");

   var_load_a: assert property (
      (state != ST_VARIABLE && next_state == ST_VARIABLE) |=>
         (units == $past(shift_amount)))
      else $error("variable mode did not load the shift amount");

endmodule : fps_top
`default_nettype wire

/* tb/fps_step_model.sv */
// user-side model driving the phase step pins
`timescale 1ns/10ps
`default_nettype none
module fps_step_model (
   input wire logic clk,         // system clock
   output logic step_en,         // phase_step_enable pin
   output logic step_clk,        // phase_step_clock pin
   output logic step_dir         // phase_step_direction pin
);
   // ****************************************
   // idle: all pins held low
   // ****************************************
   // low between steps, so none and fixed modes see tied-off pins
   initial begin
      step_en = 1'b0;
      step_clk = 1'b0;
      step_dir = 1'b0;
   end

   // ****************************************
   // one step request
   // ****************************************
   // enable and direction settle 3 cycles before the step clock rises
   task automatic step(input logic up, input int hold);
      @(posedge clk);
      step_en <= 1'b1;
      step_dir <= up;
      repeat (3) @(posedge clk);
      step_clk <= 1'b1;
      repeat (hold) @(posedge clk);
      step_clk <= 1'b0;
      repeat (hold) @(posedge clk);
      step_en <= 1'b0;
      step_dir <= 1'b0;
   endtask : step
endmodule : fps_step_model
`default_nettype wire

/* tb/fine_phase_shift_control_test.sv */
// self-checking bench for the fine phase shift control block
`timescale 1ns/10ps
`default_nettype none
`include "fps_defs.svh"
module fine_phase_shift_control_test;
   import fps_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic low_freq_mode = 1'b0;
   fps_mode_t mode = FPS_NONE;
   logic signed [8:0] shift = 9'sh000;
   logic [15:0] period = 16'h2710;
   logic step_en, step_clk, step_dir;
   logic active, cfg_err, later, earlier, done, stray;
   logic signed [8:0] units;
   logic signed [16:0] tps;
   logic [15:0] res;
   logic [8:0][10:0] phase;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int coarse [9] = '{`FPS_CO_ZERO, `FPS_CO_QUARTER, `FPS_CO_HALF,
      `FPS_CO_THREE_Q, `FPS_CO_ZERO, `FPS_CO_HALF, `FPS_CO_ZERO,
      `FPS_CO_ZERO, `FPS_CO_HALF};

   always #5 clk = ~clk;

   fps_top u_dut (.clk(clk), .rst(rst), .low_freq_mode(low_freq_mode),
      .shift_mode_attribute(mode), .shift_amount(shift),
      .ref_period_ps(period), .phase_step_enable(step_en),
      .phase_step_clock(step_clk), .phase_step_direction(step_dir),
      .shift_active(active), .config_error(cfg_err),
      .fine_shift_units(units), .fine_shift_time_ps(tps),
      .resolution_ps(res), .feedback_later(later),
      .feedback_earlier(earlier), .step_done(done), .stray_step(stray),
      .out_phase(phase));

   fps_step_model u_model (.clk(clk), .step_en(step_en),
      .step_clk(step_clk), .step_dir(step_dir));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   // a hung wait for step_done would otherwise stall the run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   // outputs trail the config by two edges; three leaves margin
   task automatic apply(input logic lf, input fps_mode_t m,
         input logic signed [8:0] s);
      @(posedge clk);
      low_freq_mode <= lf;
      mode <= m;
      shift <= s;
      repeat (3) @(posedge clk);
      #1;
   endtask : apply

   task automatic chk_shift(input int s);
      int r;
      r = (period >> 8) > `FPS_TAP_PS_DEF ? period >> 8 : `FPS_TAP_PS_DEF;
      chk("units", s, units);
      chk("time", int'(period) * s / 256, tps);
      chk("resolution", r, res);
      chk("later", s > 0, later);
      chk("earlier", s < 0, earlier);
      for (int i = 0; i < 9; i++) begin
         chk("phase", coarse[i] + s, $signed(phase[i]));
      end
   endtask : chk_shift

   // with hold 3 the outputs move on the edge the model returns on, so look 1 ns later
   task automatic do_step(input logic up, input int hold, input int exp,
         input logic vmode);
      logic seen_done;
      logic seen_stray;
      seen_done = 1'b0;
      seen_stray = 1'b0;
      fork
         u_model.step(up, hold);
         for (int k = 0; k < 40 && !(seen_done || seen_stray); k++) begin
            @(negedge clk);
            seen_done = (done === 1'b1);
            seen_stray = (stray === 1'b1);
         end
      join
      #1;
      chk("step_done", vmode, seen_done);
      chk("stray_step", !vmode, seen_stray);
      chk_shift(exp);
   endtask : do_step

   // ****************************************
   // scenarios
   // ****************************************
   task automatic test_off();
      apply(1'b1, FPS_NONE, 9'sh00A);
      chk("active", 0, active);
      chk_shift(0);
      apply(1'b0, FPS_FIXED, 9'sh00A);
      chk("active", 0, active);
      chk("units", 0, units);
   endtask : test_off

   task automatic test_bad();
      apply(1'b1, FPS_FIXED, 9'sh100);
      chk("cfg_err", 1, cfg_err);
      chk("units", 0, units);
      apply(1'b1, fps_mode_t'(2'h3), 9'sh005);
      chk("cfg_err", 1, cfg_err);
      apply(1'b1, FPS_FIXED, 9'sh1FF);
      chk("cfg_err", 0, cfg_err);
   endtask : test_bad

   task automatic test_fixed();
      int vals [5] = '{10, -10, 0, 255, -255};
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         period <= (p == 0) ? 16'h2710 : 16'h0A00;
         foreach (vals[i]) begin
            apply(1'b1, FPS_FIXED, 9'(vals[i]));
            chk("active", 1, active);
            chk_shift(vals[i]);
         end
      end
   endtask : test_fixed

   task automatic test_var();
      @(posedge clk);
      period <= 16'h2710;
      apply(1'b1, FPS_NONE, 9'sh000);
      apply(1'b1, FPS_VARIABLE, 9'sh0FE);
      chk("active", 1, active);
      chk_shift(254);
      do_step(1'b1, 3, 255, 1'b1);
      do_step(1'b1, 8, 255, 1'b1);
      do_step(1'b0, 3, 254, 1'b1);
      apply(1'b1, FPS_NONE, 9'sh000);
      apply(1'b1, FPS_VARIABLE, 9'sh101);
      do_step(1'b0, 8, -255, 1'b1);
      do_step(1'b1, 3, -254, 1'b1);
   endtask : test_var

   // pins pulsed where they should be tied off: no step, stray flagged
   task automatic test_stray();
      apply(1'b1, FPS_FIXED, 9'sh014);
      do_step(1'b1, 3, 20, 1'b0);
      apply(1'b1, FPS_NONE, 9'sh014);
      do_step(1'b0, 3, 0, 1'b0);
   endtask : test_stray

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      test_off();
      test_bad();
      test_fixed();
      test_var();
      test_stray();
      report_and_stop();
   end
endmodule : fine_phase_shift_control_test
`default_nettype wire
